// ===== enc_out_cfg.svh
// Constants of the encoder pulse divider: widths, limits, timing counts.
// Assumes a single 100 MHz clock; included by the package and by modules.
`ifndef ENC_OUT_CFG_SVH
`define ENC_OUT_CFG_SVH

// ************************************************************
// Timing
// ************************************************************
`define CLK_HZ              100000000
`define MAX_PULSE_RATE_PPS  1600000
`define QUAD_PER_PULSE      4
// Least gap between two output edges, rounded down to whole cycles
`define EDGE_GAP_CYC  (`CLK_HZ / (`QUAD_PER_PULSE * `MAX_PULSE_RATE_PPS))

// ************************************************************
// Widths
// ************************************************************
`define CNT_W      31
`define ACC_W      22
`define SPD_W      16
`define BACKLOG_W  8
`define GAP_W      5

// ************************************************************
// Output pulse count setting
// ************************************************************
`define CNT_MIN        31'h00000010
`define CNT_MAX        31'h40000000
`define CNT_DEFAULT    31'h00000800
`define CNT_MAX_RES13  31'h00000800
`define CNT_MAX_RES17  31'h00008000
`define CNT_MAX_RES20  31'h00040000
`define TIER1_TOP      31'h00004000
`define TIER2_TOP      31'h00008000
`define TIER3_TOP      31'h00010000
`define TIER4_TOP      31'h00020000

// ************************************************************
// Native encoder counts per revolution
// ************************************************************
`define RES13_PULSES  22'h002000
`define RES17_PULSES  22'h020000
`define RES20_PULSES  22'h100000

// ************************************************************
// Speed limits per count tier, rpm
// ************************************************************
`define SPD_LIM_T1  16'h1770
`define SPD_LIM_T2  16'h0BB8
`define SPD_LIM_T3  16'h05DC
`define SPD_LIM_T4  16'h02EE
`define SPD_LIM_T5  16'h0177

`endif

// ===== enc_out_pkg.sv
// Types shared by the divider and the quadrature generator.
// Assumes enc_out_cfg.svh is on the include path.
`include "enc_out_cfg.svh"

package enc_out_pkg;

   typedef enum logic [1:0] {
      RES_13   = 2'b00,
      RES_17   = 2'b01,
      RES_20   = 2'b10,
      RES_NONE = 2'b11
   } res_sel_t;

   typedef enum logic [1:0] {
      ST_LOAD  = 2'b00,
      ST_RUN   = 2'b01,
      ST_FAULT = 2'b10
   } run_state_t;

   typedef struct packed {
      run_state_t            st;
      logic [`CNT_W-1:0]     count;
      res_sel_t              res;
      logic [`ACC_W-1:0]     acc;
      logic                  set_err;
      logic                  overspeed;
      logic                  step_req;
      logic                  step_fwd;
      logic                  origin_req;
   } div_state_t;

   typedef struct packed {
      logic [1:0]            phase;
      logic [`BACKLOG_W-1:0] backlog;
      logic [`GAP_W-1:0]     gap;
      logic                  armed;
      logic                  pa;
      logic                  pa_n;
      logic                  pb;
      logic                  pb_n;
      logic                  pc;
      logic                  pc_n;
   } quad_state_t;

endpackage : enc_out_pkg

// ===== quad_link_if.sv
// Link between the divider and the quadrature phase generator.
// Assumes both ends run on the same clock; all signals but run, a decode of the divider state, are registered.
interface quad_link_if;
   logic step_req;    // One quarter step wanted
   logic step_fwd;    // Direction of that step
   logic origin_req;  // Origin seen this cycle
   logic run;         // Setting accepted, output allowed
   logic pa;
   logic pa_inv;
   logic pb;
   logic pb_inv;
   logic pc;
   logic pc_inv;

   modport divider (
      output step_req, step_fwd, origin_req, run,
      input  pa, pa_inv, pb, pb_inv, pc, pc_inv
   );
   modport gen (
      input  step_req, step_fwd, origin_req, run,
      output pa, pa_inv, pb, pb_inv, pc, pc_inv
   );
endinterface : quad_link_if

// ===== quad_phase_gen.sv
// Quadrature phase generator: turns quarter steps into phases A, B, C.
// Assumes step requests come from the divider at most one per cycle.
`include "enc_out_cfg.svh"

module quad_phase_gen
   import enc_out_pkg::*;
(
   input wire logic ref_clk,  // System clock
   input wire logic nrst,     // Async reset, active low
   quad_link_if.gen link      // Steps in, phases out
);

   quad_state_t st_ff;
   quad_state_t nxt_st;

   function automatic logic phase_a_of(input logic [1:0] p);
      return p[1] ^ p[0];
   endfunction : phase_a_of

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      logic [`BACKLOG_W-1:0] bl;
      logic                  a_now;
      bl = st_ff.backlog;
      a_now = 1'b0;
      nxt_st = st_ff;
      nxt_st.gap = (st_ff.gap != '0) ? st_ff.gap - 1'b1 : '0;
      if (link.step_req) begin
         bl = link.step_fwd ? bl + 1'b1 : bl - 1'b1;
      end
      // Steps queue up so a short burst is spread, never dropped
      if (bl != '0 && st_ff.gap == '0) begin  // see [R12]
         if (bl[`BACKLOG_W-1]) begin
            nxt_st.phase = st_ff.phase - 1'b1;
            bl = bl + 1'b1;
         end else begin
            nxt_st.phase = st_ff.phase + 1'b1;  // see [R1]
            bl = bl - 1'b1;
         end
         nxt_st.gap = `GAP_W'(`EDGE_GAP_CYC - 1);
      end
      nxt_st.backlog = bl;
      a_now = phase_a_of(nxt_st.phase);
      if (link.origin_req) begin
         nxt_st.armed = 1'b1;
      end
      // Origin rides on one whole A-high interval, either direction
      if (a_now && !st_ff.pa && nxt_st.armed) begin  // see [R4]
         nxt_st.pc = 1'b1;
         nxt_st.armed = 1'b0;
      end else if (!a_now) begin
         nxt_st.pc = 1'b0;
      end
      if (!link.run) begin
         nxt_st.backlog = '0;
         nxt_st.armed = 1'b0;
      end
      nxt_st.pa = a_now;
      nxt_st.pb = nxt_st.phase[1];  // see [R1]
      nxt_st.pa_n = ~nxt_st.pa;     // see [R15]
      nxt_st.pb_n = ~nxt_st.pb;
      nxt_st.pc_n = ~nxt_st.pc;
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         st_ff <= '{phase: 2'h0, backlog: '0, gap: '0, armed: 1'b0,
                    pa: 1'b0, pa_n: 1'b1, pb: 1'b0, pb_n: 1'b1,
                    pc: 1'b0, pc_n: 1'b1};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign link.pa     = st_ff.pa;
   assign link.pa_inv = st_ff.pa_n;
   assign link.pb     = st_ff.pb;
   assign link.pb_inv = st_ff.pb_n;
   assign link.pc     = st_ff.pc;
   assign link.pc_inv = st_ff.pc_n;

   // ************************************************************
   // Checks
   // ************************************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   property p_quarter_offset;
      $changed(st_ff.pa) |-> $stable(st_ff.pb);
   endproperty
   a_quarter_offset: assert property (p_quarter_offset)  // see [R1]
      else $error("A and B switched in the same cycle");

   property p_pairs_inverse;
      (st_ff.pa_n == ~st_ff.pa) && (st_ff.pb_n == ~st_ff.pb)
         && (st_ff.pc_n == ~st_ff.pc);
   endproperty
   a_pairs_inverse: assert property (p_pairs_inverse)  // see [R15]
      else $error("Inverted output does not match its phase");

   property p_edge_gap;
      $changed({st_ff.pa, st_ff.pb}) |=>
         !$changed({st_ff.pa, st_ff.pb}) [*8];
   endproperty
   a_edge_gap: assert property (p_edge_gap)  // see [R12]
      else $error("Output edges closer than the pulse rate allows");

   property p_origin_in_a;
      st_ff.pc |-> st_ff.pa;
   endproperty
   a_origin_in_a: assert property (p_origin_in_a)  // see [R4]
      else $error("Origin pulse outside the A-high interval");

endmodule : quad_phase_gen

// ===== encoder_pulse_divider_output.sv
// Encoder pulse divider: scales native encoder steps to the set count
// and re-outputs them as quadrature feedback with an origin pulse.
// Assumes encoder steps, index and speed arrive synchronous to ref_clk.
//
// What this block does
// [R1] Phases A and B are offset by a quarter period, 90 degrees.
// [R2] Exactly the set count of pulses leaves per motor revolution.
// [R3] One origin pulse on phase C per revolution.
// [R4] Origin pulse width equals the width of an A pulse.
// [R5] Phase relation is the same in either rotation direction setting.
// [R6] Output pulses come from dividing the native count internally.
// [R7] Count 16 to 2^30, default 2048, taken only at restart.
// [R8] Larger counts need steps of 2, 4, 8, 16 per tier.
// [R9] Encoder resolution caps the count: 2048, 32768, 262144.
// [R10] Bad range or step raises the setting error alarm.
// [R11] Speed above the tier limit raises the overspeed alarm.
// [R12] Output pulse rate never exceeds about 1.6 Mpps.
// [R13] Host homing on C: two turns first, else 600 rpm or less.
// [R14] Accumulate scaled steps; one quadrature advance per quarter pulse.
// [R15] Every phase is driven with its inverted twin.
`include "enc_out_cfg.svh"

module encoder_pulse_divider_output
   import enc_out_pkg::*;
(
   input  wire logic              ref_clk,                     // Clock
   input  wire logic              nrst,                        // Reset, low
   input  wire logic              enc_step_valid,              // Native step
   input  wire logic              enc_step_fwd,                // Step is fwd
   input  wire logic              enc_index,                   // Rev origin
   input  wire logic [1:0]        encoder_resolution_sel,      // 13/17/20 bit
   input  wire logic [`CNT_W-1:0] output_pulse_count_setting,  // Pulses/rev
   input  wire logic [`SPD_W-1:0] motor_speed_rpm,             // Speed, rpm
   output logic                   feedback_phase_a_out,        // Phase A
   output logic                   feedback_phase_a_out_inv,    // Phase A inv
   output logic                   feedback_phase_b_out,        // Phase B
   output logic                   feedback_phase_b_out_inv,    // Phase B inv
   output logic                   feedback_origin_out,         // Phase C
   output logic                   feedback_origin_out_inv,     // Phase C inv
   output logic                   setting_error_alarm,         // Bad count
   output logic                   overspeed_alarm              // Too fast
);

   div_state_t  st_ff;
   div_state_t  nxt_st;
   quad_link_if link ();

   // ************************************************************
   // Helpers
   // ************************************************************
   function automatic logic [`ACC_W-1:0] res_pulses(input res_sel_t r);
      case (r)
         RES_13:  return `RES13_PULSES;
         RES_17:  return `RES17_PULSES;
         RES_20:  return `RES20_PULSES;
         default: return `RES20_PULSES;
      endcase
   endfunction : res_pulses

   function automatic logic [`CNT_W-1:0] max_count(input res_sel_t r);
      case (r)
         RES_13:  return `CNT_MAX_RES13;  // see [R9]
         RES_17:  return `CNT_MAX_RES17;
         RES_20:  return `CNT_MAX_RES20;
         default: return '0;
      endcase
   endfunction : max_count

   // Step granularity coarsens with the tier the count falls in
   function automatic logic step_bad(input logic [`CNT_W-1:0] c);
      if (c <= `TIER1_TOP) begin
         return 1'b0;
      end else if (c <= `TIER2_TOP) begin
         return c[0];  // see [R8]
      end else if (c <= `TIER3_TOP) begin
         return |c[1:0];
      end else if (c <= `TIER4_TOP) begin
         return |c[2:0];
      end else begin
         return |c[3:0];
      end
   endfunction : step_bad

   function automatic logic setting_bad(input logic [`CNT_W-1:0] c,
                                        input res_sel_t          r);
      logic bad;
      bad = (c < `CNT_MIN) || (c > `CNT_MAX);  // see [R7]
      bad = bad || (c > max_count(r)) || step_bad(c);  // see [R10]
      return bad;
   endfunction : setting_bad

   function automatic logic [`SPD_W-1:0] speed_limit(
      input logic [`CNT_W-1:0] c);
      if (c <= `TIER1_TOP) begin
         return `SPD_LIM_T1;  // see [R11]
      end else if (c <= `TIER2_TOP) begin
         return `SPD_LIM_T2;
      end else if (c <= `TIER3_TOP) begin
         return `SPD_LIM_T3;
      end else if (c <= `TIER4_TOP) begin
         return `SPD_LIM_T4;
      end else begin
         return `SPD_LIM_T5;
      end
   endfunction : speed_limit

   // Four quadrature edges per output pulse; valid counts fit 20 bits
   function automatic logic [`ACC_W-1:0] quarter_inc(
      input logic [`CNT_W-1:0] c);
      return {c[`ACC_W-3:0], 2'b00};
   endfunction : quarter_inc

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      logic [`ACC_W:0]   sum;
      logic [`ACC_W-1:0] inc;
      logic [`ACC_W-1:0] res;
      sum = '0;
      inc = quarter_inc(st_ff.count);
      res = res_pulses(st_ff.res);
      nxt_st = st_ff;
      nxt_st.step_req = 1'b0;
      nxt_st.origin_req = 1'b0;
      case (st_ff.st)
         // Setting is sampled once after reset; later changes wait
         // for the next restart
         ST_LOAD: begin
            nxt_st.count = output_pulse_count_setting;  // see [R7]
            nxt_st.res = res_sel_t'(encoder_resolution_sel);
            nxt_st.acc = '0;
            nxt_st.set_err = setting_bad(output_pulse_count_setting,
                                         res_sel_t'(encoder_resolution_sel));
            nxt_st.st = nxt_st.set_err ? ST_FAULT : ST_RUN;  // see [R10]
         end
         ST_RUN: begin
            if (enc_step_valid) begin
               // Direction follows the shaft only, so the A/B/C form
               // is the same for both direction settings
               nxt_st.step_fwd = enc_step_fwd;  // see [R5]
               if (enc_step_fwd) begin
                  sum = {1'b0, st_ff.acc} + {1'b0, inc};  // see [R14]
                  if (sum >= {1'b0, res}) begin
                     nxt_st.acc = `ACC_W'(sum - {1'b0, res});  // see [R6]
                     nxt_st.step_req = 1'b1;
                  end else begin
                     nxt_st.acc = sum[`ACC_W-1:0];
                  end
               end else begin
                  if (st_ff.acc < inc) begin
                     nxt_st.acc = st_ff.acc + res - inc;  // see [R14]
                     nxt_st.step_req = 1'b1;
                  end else begin
                     nxt_st.acc = st_ff.acc - inc;
                  end
               end
            end
            nxt_st.origin_req = enc_index;  // see [R3]
            // Alarm holds until restart so a brief excursion is seen
            if (motor_speed_rpm > speed_limit(st_ff.count)) begin
               nxt_st.overspeed = 1'b1;  // see [R11]
            end
         end
         ST_FAULT: begin
            nxt_st.set_err = 1'b1;
         end
         default: begin
            nxt_st.st = ST_FAULT;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         st_ff <= '{st: ST_LOAD, count: `CNT_DEFAULT, res: RES_13,
                    acc: '0, set_err: 1'b0, overspeed: 1'b0,
                    step_req: 1'b0, step_fwd: 1'b0, origin_req: 1'b0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ************************************************************
   // Phase generator and outputs
   // ************************************************************
   assign link.step_req   = st_ff.step_req;
   assign link.step_fwd   = st_ff.step_fwd;
   assign link.origin_req = st_ff.origin_req;
   assign link.run        = (st_ff.st == ST_RUN);  // see [R2]

   quad_phase_gen u_quad (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .link    (link.gen)
   );

   assign feedback_phase_a_out     = link.pa;
   assign feedback_phase_a_out_inv = link.pa_inv;
   assign feedback_phase_b_out     = link.pb;
   assign feedback_phase_b_out_inv = link.pb_inv;
   assign feedback_origin_out      = link.pc;
   assign feedback_origin_out_inv  = link.pc_inv;
   assign setting_error_alarm      = st_ff.set_err;
   assign overspeed_alarm          = st_ff.overspeed;

   // ************************************************************
   // Checks
   // ************************************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   sequence s_load;
      st_ff.st == ST_LOAD;
   endsequence

   sequence s_verdict;
      ##1 (st_ff.st != ST_LOAD)
         && (setting_error_alarm == (st_ff.st == ST_FAULT));
   endsequence

   property p_setting_verdict;
      s_load |-> s_verdict ##0
         (setting_error_alarm ==
          setting_bad($past(output_pulse_count_setting),
                      res_sel_t'($past(encoder_resolution_sel))));
   endproperty
   a_setting_verdict: assert property (p_setting_verdict)  // see [R10]
      else $error("Setting alarm disagrees with the loaded count");

   property p_fault_silent;
      (st_ff.st == ST_FAULT) |-> !link.step_req && !link.origin_req;
   endproperty
   a_fault_silent: assert property (p_fault_silent)  // see [R10]
      else $error("Pulses issued with a rejected setting");

   property p_acc_bounded;
      (st_ff.st == ST_RUN) |-> (st_ff.acc < res_pulses(st_ff.res));
   endproperty
   a_acc_bounded: assert property (p_acc_bounded)  // see [R6]
      else $error("Divider remainder left its range");

   property p_fwd_wrap;
      (st_ff.st == ST_RUN) && enc_step_valid && enc_step_fwd
         && ({1'b0, st_ff.acc} + {1'b0, quarter_inc(st_ff.count)}
             >= {1'b0, res_pulses(st_ff.res)})
         |=> link.step_req && link.step_fwd;
   endproperty
   a_fwd_wrap: assert property (p_fwd_wrap)  // see [R14]
      else $error("Quarter pulse due but no forward step issued");

   property p_no_step_idle;
      !enc_step_valid |=> !link.step_req;
   endproperty
   a_no_step_idle: assert property (p_no_step_idle)  // see [R2]
      else $error("Step issued without an encoder step");

   property p_overspeed_set;
      (st_ff.st == ST_RUN) && (motor_speed_rpm > speed_limit(st_ff.count))
         |=> overspeed_alarm;
   endproperty
   a_overspeed_set: assert property (p_overspeed_set)  // see [R11]
      else $error("Overspeed not flagged above the tier limit");

   property p_overspeed_hold;
      overspeed_alarm |=> overspeed_alarm [*2];
   endproperty
   a_overspeed_hold: assert property (p_overspeed_hold)  // see [R11]
      else $error("Overspeed alarm dropped before restart");

   property p_origin_follows_index;
      (st_ff.st == ST_RUN) && enc_index |=> link.origin_req;
   endproperty
   a_origin_follows_index: assert property (p_origin_follows_index) // see [R3]
      else $error("Encoder index not passed on as origin request");

endmodule : encoder_pulse_divider_output

// ===== enc_host_model.sv
// Host side model: decodes quadrature feedback and times the origin pulse.
// Assumes the phases are registered on ref_clk and reset with nrst.
module enc_host_model (
   input  wire logic ref_clk,   // Clock
   input  wire logic nrst,      // Reset, low
   input  wire logic pa,        // Phase A
   input  wire logic pa_n,      // Phase A inv
   input  wire logic pb,        // Phase B
   input  wire logic pb_n,      // Phase B inv
   input  wire logic pc,        // Phase C
   input  wire logic pc_n,      // Phase C inv
   output int        pos,       // Signed quarter count
   output int        bad_seq,   // Skipped states
   output int        bad_pair,  // Twin mismatches
   output int        origins,   // Origin pulses seen
   output int        a_w,       // Last A high width
   output int        c_w,       // Last C high width
   output int        min_gap    // Least edge spacing
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] idx;
   logic [1:0] prev_ff;
   logic       pa_ff;
   logic       pc_ff;
   int         a_cnt;
   int         c_cnt;
   int         gap;
   // Forward order 0,1,2,3 means A leads B
   assign idx = pa ? (pb ? 2'h2 : 2'h1) : (pb ? 2'h3 : 2'h0);
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         prev_ff  <= 2'h0;
         pa_ff    <= 1'b0;
         pc_ff    <= 1'b0;
         pos      <= 0;
         bad_seq  <= 0;
         bad_pair <= 0;
         origins  <= 0;
         a_w      <= 0;
         c_w      <= 0;
         a_cnt    <= 0;
         c_cnt    <= 0;
         min_gap  <= 1000;
         // Large start so the first edge after reset is not a short gap
         gap      <= 1000;
      end else begin
         prev_ff <= idx;
         pa_ff   <= pa;
         pc_ff   <= pc;
         gap     <= gap + 1;
         a_cnt   <= pa ? a_cnt + 1 : 0;
         c_cnt   <= pc ? c_cnt + 1 : 0;
         if (idx != prev_ff) begin
            gap <= 1;
            if (gap < min_gap) min_gap <= gap;
            case (2'(idx - prev_ff))
               2'h1: pos <= pos + 1;
               2'h3: pos <= pos - 1;
               default: bad_seq <= bad_seq + 1;
            endcase
         end
         if (pa !== ~pa_n || pb !== ~pb_n || pc !== ~pc_n) begin
            bad_pair <= bad_pair + 1;
         end
         if (pa_ff && !pa) a_w <= a_cnt;
         if (pc_ff && !pc) begin
            c_w     <= c_cnt;
            origins <= origins + 1;
         end
      end
   end
endmodule : enc_host_model

// ===== encoder_pulse_divider_output_bench.sv
// Self-checking bench of the encoder pulse divider with a host decoder.
// Assumes enc_out_cfg.svh on the include path and enc_out_pkg compiled.
`include "enc_out_cfg.svh"
module encoder_pulse_divider_output_bench
   import enc_out_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk, nrst, enc_step_valid, enc_step_fwd, enc_index;
   logic [1:0]        res;
   logic [`CNT_W-1:0] cnt;
   logic [`SPD_W-1:0] spd;
   logic pa, pa_n, pb, pb_n, pc, pc_n, set_err, ovs;
   int   pos, bad_seq, bad_pair, origins, a_w, c_w, min_gap;
   int   fails, checked;
   logic [1:0]        s_res [15] = '{0, 0, 0, 0, 1, 1, 1, 1, 2, 2, 2, 2,
      3, 2, 2};
   logic [`CNT_W-1:0] s_cnt [15] = '{16, 15, 2048, 2049, 32768, 32770, 16385,
      65536, 262144, 262160, 131088, 65540, 2048, 262145, 31'h40000000};
   // 32770 lies above the 17 bit cap of 32768, so it must be refused
   logic              s_err [15] = '{0, 1, 0, 1, 0, 1, 1, 1, 0, 1, 0, 1,
      1, 1, 1};
   logic [`CNT_W-1:0] o_cnt [5] = '{16384, 32768, 65536, 131072, 262144};
   logic [`SPD_W-1:0] o_lim [5] = '{6000, 3000, 1500, 750, 375};

   encoder_pulse_divider_output i_dut (
      .ref_clk(ref_clk), .nrst(nrst), .enc_step_valid(enc_step_valid),
      .enc_step_fwd(enc_step_fwd), .enc_index(enc_index),
      .encoder_resolution_sel(res), .output_pulse_count_setting(cnt),
      .motor_speed_rpm(spd), .feedback_phase_a_out(pa),
      .feedback_phase_a_out_inv(pa_n), .feedback_phase_b_out(pb),
      .feedback_phase_b_out_inv(pb_n), .feedback_origin_out(pc),
      .feedback_origin_out_inv(pc_n), .setting_error_alarm(set_err),
      .overspeed_alarm(ovs));
   enc_host_model i_host (
      .ref_clk(ref_clk), .nrst(nrst), .pa(pa), .pa_n(pa_n), .pb(pb),
      .pb_n(pb_n), .pc(pc), .pc_n(pc_n), .pos(pos), .bad_seq(bad_seq),
      .bad_pair(bad_pair), .origins(origins), .a_w(a_w), .c_w(c_w),
      .min_gap(min_gap));

   // ************************************************************
   // Shared tasks
   // ************************************************************
   task automatic check(input string what, input logic [31:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("Error %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check

   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : report_and_stop

   task automatic restart(input logic [1:0] r, input logic [`CNT_W-1:0] c);
      @(posedge ref_clk);
      nrst <= 1'b0;
      res  <= r;
      cnt  <= c;
      spd  <= 16'h0000;
      repeat (2) @(posedge ref_clk);
      nrst <= 1'b1;
      repeat (3) @(posedge ref_clk);
   endtask : restart

   // Native steps one per cycle; optional index at step 64
   task automatic steps(input int n, input logic f, input logic with_idx);
      for (int i = 0; i < n; i++) begin
         @(posedge ref_clk);
         enc_step_valid <= 1'b1;
         enc_step_fwd   <= f;
         enc_index      <= with_idx && i == 64;
      end
      @(posedge ref_clk);
      enc_step_valid <= 1'b0;
      enc_index      <= 1'b0;
   endtask : steps

   task automatic wait_pos(input int exp);
      int k;
      for (k = 0; k < 2000 && pos != exp; k++) @(posedge ref_clk);
      if (k == 2000) begin
         fails++;
         report_and_stop();
      end
      repeat (300) @(posedge ref_clk);
   endtask : wait_pos

   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic t_reset();
      check("a in reset", {pa, pa_n, pb, pb_n}, 32'h5);
      check("c in reset", {pc, pc_n, set_err, ovs}, 32'h4);
   endtask : t_reset

   // 16 pulses per rev on 13 bit: 64 quarters per 8192 native steps
   task automatic t_rev();
      restart(RES_13, 31'h00000010);
      // Index given while speed reads 0, a slow homing pass
      steps(32'h2000, 1'b1, 1'b1);
      wait_pos(32'h40);
      check("pos fwd", pos, 32'h40);
      check("origins", origins, 32'h1);
      check("c width", c_w, a_w);
      check("a width", a_w, 32'h100);
      steps(32'h2000, 1'b0, 1'b0);
      wait_pos(32'h0);
      check("pos rev", pos, 32'h0);
      check("sequence", bad_seq, 32'h0);
      check("twins", bad_pair, 32'h0);
   endtask : t_rev

   // Back to back steps at one edge each are paced out
   task automatic t_pace();
      restart(RES_13, 31'h00000800);
      steps(32'h14, 1'b1, 1'b0);
      wait_pos(32'h14);
      check("pos paced", pos, 32'h14);
      check("gap", min_gap >= 15, 32'h1);
   endtask : t_pace

   task automatic t_settings();
      for (int i = 0; i < 15; i++) begin
         restart(s_res[i], s_cnt[i]);
         check("set alarm", set_err, s_err[i]);
         cnt <= 31'h00000800;
         steps(32'h32, 1'b1, 1'b1);
         repeat (20) @(posedge ref_clk);
         check("alarm kept", set_err, s_err[i]);
         if (s_err[i]) check("no pulses", pos, 32'h0);
      end
   endtask : t_settings

   task automatic t_overspeed();
      for (int i = 0; i < 5; i++) begin
         restart(RES_20, o_cnt[i]);
         check("tier top", set_err, 32'h0);
         spd <= o_lim[i];
         repeat (3) @(posedge ref_clk);
         check("at limit", ovs, 32'h0);
         spd <= o_lim[i] + 16'h0001;
         repeat (3) @(posedge ref_clk);
         check("above limit", ovs, 32'h1);
         spd <= 16'h0000;
         repeat (3) @(posedge ref_clk);
         check("sticky", ovs, 32'h1);
      end
   endtask : t_overspeed

   // ************************************************************
   // Clock and main sequence
   // ************************************************************
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   initial begin
      fails = 0;
      checked = 0;
      nrst = 1'b0;
      enc_step_valid = 1'b0;
      enc_step_fwd = 1'b0;
      enc_index = 1'b0;
      res = RES_13;
      cnt = 31'h00000800;
      spd = 16'h0000;
      repeat (6) @(posedge ref_clk);
      t_reset();
      nrst <= 1'b1;
      t_rev();
      t_pace();
      t_settings();
      t_overspeed();
      report_and_stop();
   end
endmodule : encoder_pulse_divider_output_bench
